/* dv/cn_residual_source.sv */
`default_nettype none
module cn_residual_source
	import cn_smoother_pkg::*;
#(
	parameter int unsigned SAMPLES = 256
)(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  go,
	input  wire comp_t level,
	output var  logic  sampleValid,
	output var  comp_t residual,
	output var  logic  busy
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [9:0] left;

	// one frame of residual samples; idle line carries the inverse, never a stale copy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left        <= '0;
			sampleValid <= 1'b0;
			residual    <= '0;
		end else begin
			sampleValid <= (left != '0);
			residual    <= (left != '0) ? level : ~residual;
			left        <= go ? 10'(SAMPLES) : ((left != '0) ? left - 10'h001 : left);
		end
	end

	// busy until the last sample has been presented
	always_comb begin
		busy = (left != '0) || sampleValid;
	end
endmodule
`default_nettype wire

/* dv/comfort_noise_param_smoother_bench.sv */
`default_nettype none
module comfort_noise_param_smoother_bench
	import cn_smoother_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk;
	logic       rst_n;
	frame_in_t  fin;
	energy_in_t ein;
	vec_t       qVec;
	vec_t       hoVec;
	vec_t       endV;
	vec_t       expVec;
	result_t    res;
	lpc_t       coef;
	logic       lpcValid;
	logic       sampleValid;
	comp_t      residual;
	comp_t      level;
	logic       go;
	logic       busy;
	int         errCount;
	int         checks;

	cn_param_smoother i_dut (
		.clk                          (clk),
		.rst_n                        (rst_n),
		.frameIn                      (fin),
		.energyIn                     (ein),
		.sampleValid                  (sampleValid),
		.residual                     (residual),
		.quantVec                     (qVec),
		.hangoverWeightedSpectralMean (hoVec),
		.endVec                       (endV),
		.result                       (res),
		.lpcCoef                      (coef),
		.lpcValid                     (lpcValid)
	);

	cn_residual_source #(.SAMPLES(256)) i_src (
		.clk         (clk),
		.rst_n       (rst_n),
		.go          (go),
		.level       (level),
		.sampleValid (sampleValid),
		.residual    (residual),
		.busy        (busy)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	function automatic vec_t ramp(input comp_t base, input comp_t step);
		vec_t v;
		for (int k = 0; k < VEC_LEN; k++) begin
			v[k] = comp_t'(base + step * comp_t'(k));
		end
		return v;
	endfunction

	// tolerance covers the rounding of the fixed-point weights
	task automatic checkVec(input string what, input vec_t e, input int tol);
		for (int k = 0; k < VEC_LEN; k++) begin
			check(what, 1'b1, (res.smVec[k] - e[k] <= tol) && (e[k] - res.smVec[k] <= tol));
		end
	endtask

	task automatic checkLog();
		int e;
		real r;
		logic ok;
		e = $rtoi((real'(res.idx) / 5.25 - 2.0) * 256.0);
		r = (2.0 ** (real'(res.idx) / 5.25 - 2.0)) * 256.0;
		check("eLog", 1'b1, ($signed(res.eLog) - e <= 2) && (e - $signed(res.eLog) <= 2));
		// linear fraction in the power of two reads high by up to about six percent
		ok = (real'(res.eLin) <= r * 1.07 + 2.0) && (real'(res.eLin) >= r * 0.93 - 2.0);
		check("eLin", 1'b1, ok);
	endtask

	// offset is internal state; read it where it is held
	task automatic checkOff(input string what, input real v);
		int e;
		e = $rtoi(v * 256.0);
		check(what, 1'b1, (i_dut.st.offset - e <= 1) && (e - i_dut.st.offset <= 1));
	endtask

	task automatic setVec(input vec_t q, input vec_t h);
		@(posedge clk);
		qVec  <= q;
		hoVec <= h;
	endtask

	// one frame of residual, strobe kept clear of the samples
	task automatic feed();
		int n;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		#1;
		for (n = 0; n < 400 && busy; n++) begin
			@(posedge clk);
			#1;
		end
		check("feed done", 1'b0, busy);
	endtask

	// strobe one frame, then watch the conversion pulse land at its fixed cycle
	task automatic frame(input logic inact, sid, first, past, input logic [3:0] ho);
		int n;
		@(posedge clk);
		fin.strobe     <= 1'b1;
		fin.inactive   <= inact;
		fin.sid        <= sid;
		fin.firstSid   <= first;
		fin.pastParams <= past;
		fin.hoCount    <= ho;
		@(posedge clk);
		fin.strobe <= 1'b0;
		#1;
		for (n = 1; n <= 10; n++) begin
			check("lpcValid early", 1'b0, lpcValid);
			@(posedge clk);
			#1;
		end
		check("lpcValid", 1'b1, lpcValid);
		@(posedge clk);
		#1;
		check("lpcValid pulse", 1'b0, lpcValid);
	endtask

	task automatic tActive();
		@(posedge clk);
		endV <= ramp(16'h1000, 16'h0100);
		frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		checkVec("smVec end load", endV, 0);
		repeat (20) @(posedge clk);
		#1;
		checkVec("smVec held", endV, 0);
		$display("test active done");
	endtask

	task automatic tFirst();
		setVec(ramp(16'h0800, 16'h0200), ramp(16'h0C00, 16'h0200));
		frame(1'b1, 1'b1, 1'b1, 1'b0, 4'h4);
		checkVec("smVec no past", qVec, 0);
		@(posedge clk);
		ein.enrNewest                <= 32'h0000_0500;
		ein.smoothedExcitationEnergy <= 32'h0000_0100;
		frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		frame(1'b1, 1'b1, 1'b1, 1'b1, 4'h4);
		check("stepFlag history", 1'b1, res.stepFlag);
		checkVec("smVec step", qVec, 0);
		@(posedge clk);
		ein.enrNewest                <= 32'h0000_0000;
		ein.smoothedExcitationEnergy <= 32'hFFFF_FFFF;
		$display("test first descriptor done");
	endtask

	task automatic tOutlier();
		frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		frame(1'b1, 1'b1, 1'b1, 1'b1, 4'h4);
		check("stepFlag flat", 1'b0, res.stepFlag);
		checkVec("smVec max outlier", hoVec, 0);
		// every component 0x100 apart: max below 0.1, sum above 0.4
		setVec(qVec, ramp(16'h0900, 16'h0200));
		frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		frame(1'b1, 1'b1, 1'b1, 1'b1, 4'h4);
		checkVec("smVec sum outlier", hoVec, 0);
		$display("test outlier done");
	endtask

	task automatic tBlend();
		setVec(qVec, ramp(16'h0810, 16'h0200));
		frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		frame(1'b1, 1'b1, 1'b1, 1'b1, 4'h4);
		for (int k = 0; k < VEC_LEN; k++) begin
			expVec[k] = comp_t'($rtoi(0.8 * real'(hoVec[k]) + 0.2 * real'(qVec[k])));
		end
		checkVec("smVec blend", expVec, 2);
		setVec(ramp(16'h1000, 16'h0100), hoVec);
		frame(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
		for (int k = 0; k < VEC_LEN; k++) begin
			expVec[k] = comp_t'($rtoi(0.9 * real'(expVec[k]) + 0.1 * real'(qVec[k])));
		end
		checkVec("smVec smoothing", expVec, 3);
		// zero smoothed energy makes the last descriptor an outlier
		@(posedge clk);
		ein.smoothedExcitationEnergy <= 32'h0000_0000;
		frame(1'b1, 1'b0, 1'b0, 1'b1, 4'h3);
		checkVec("smVec suspended", expVec, 3);
		@(posedge clk);
		ein.smoothedExcitationEnergy <= 32'hFFFF_FFFF;
		$display("test blend done");
	endtask

	task automatic tEnergy();
		logic [6:0] prev;
		frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		frame(1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
		checkLog();
		prev = res.idx;
		feed();
		frame(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
		check("idx limited", 1'b1, res.idx <= 8'(prev) + 8'h01);
		check("stepFlag low", 1'b0, res.stepFlag);
		checkLog();
		prev = res.idx;
		feed();
		@(posedge clk);
		ein.instE <= 16'h0200;
		frame(1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
		check("stepFlag high", 1'b1, res.stepFlag);
		check("idx step jump", 1'b1, res.idx >= 8'(prev) + 8'h02);
		checkLog();
		$display("test energy done");
	endtask

	// once any descriptor has been sent, offset moves only after a long enough burst; a short burst keeps the old value
	task automatic tOffset();
		@(posedge clk);
		fin.bw   <= BW_WB;
		fin.rate <= 10'h048;
		repeat (20) frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		frame(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
		checkOff("offset wb 7.2k", 1.7938412);
		@(posedge clk);
		fin.rate <= 10'h060;
		frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		frame(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
		checkOff("offset short burst", 1.7938412);
		@(posedge clk);
		fin.bw     <= BW_SWB;
		fin.ioMode <= 1'b1;
		repeat (20) frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		frame(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
		checkOff("offset super", 1.5);
		$display("test offset done");
	endtask

	initial begin
		errCount = 0;
		checks   = 0;
		rst_n    = 1'b0;
		fin      = '0;
		fin.bw   = BW_NB;
		ein      = '0;
		ein.smoothedExcitationEnergy = 32'hFFFF_FFFF;
		qVec     = '0;
		hoVec    = '0;
		endV     = '0;
		expVec   = '0;
		level    = 16'h1000;
		go       = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		check("result cleared", 1'b1, res === '0);
		check("coef cleared", 1'b1, coef === '0);
		$display("test reset done");
		tActive();
		tFirst();
		tOutlier();
		tBlend();
		tEnergy();
		tOffset();
		results();
	end

	// cut a hang well beyond the 1300 or so cycles the tests need
	initial begin
		repeat (50000) @(posedge clk);
		errCount++;
		$display("[FAIL] watchdog expected finish seen timeout");
		results();
	end
endmodule
`default_nettype wire

/* rtl/cn_param_smoother.sv */
`default_nettype none
module cn_param_smoother
	import cn_smoother_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire frame_in_t  frameIn,
	input  wire energy_in_t energyIn,
	input  wire logic       sampleValid,
	input  wire comp_t      residual,
	input  wire vec_t       quantVec,
	input  wire vec_t       hangoverWeightedSpectralMean,
	input  wire vec_t       endVec,
	output var  result_t    result,
	output var  lpc_t       lpcCoef,
	output logic            lpcValid
);
	typedef struct packed {
		vec_t                 smVec;
		logic [6:0]           idx;
		comp_t                eLog;
		logic [31:0]          eLin;
		logic                 stepFlag;
		comp_t [HIST_LEN-1:0] hist;
		comp_t                offset;
		logic [47:0]          sumSq;
		logic                 wasInactive;
		logic                 afterFirstSid;
		logic                 anySid;
		logic [7:0]           activeRun;
		logic [31:0]          lastSidE;
		logic                 lpcStart;
	} smoother_state_t;

	smoother_state_t      st;
	smoother_state_t      nx;
	logic                 firstInact;
	logic                 stepNow;
	logic                 holdUpd;
	logic                 far;
	logic                 offUpd;
	logic signed [16:0]   dk;
	logic signed [16:0]   dMax;
	logic [20:0]          dSum;
	logic signed [16:0]   stepDiff;
	comp_t                eCur;
	comp_t                eAvg;
	comp_t                newOff;
	comp_t [HIST_LEN-1:0] newHist;
	logic signed [39:0]   acc;
	logic signed [58:0]   wProd;
	logic signed [23:0]   qProd;
	logic signed [23:0]   qFloor;
	logic [6:0]           rawIdx;
	logic [6:0]           idxNew;
	logic signed [8:0]    iDiff;
	logic signed [21:0]   sProd;
	logic signed [8:0]    stepSum;
	logic [22:0]          eProd;
	comp_t                eLogNew;

	// weighted blend of two components, weights unsigned Q15 summing to one
	function automatic comp_t blend(input comp_t a, input comp_t b,
		input logic [15:0] wa, input logic [15:0] wb);
		logic signed [32:0] s;
		s = 33'(a * $signed({1'b0, wa})) + 33'(b * $signed({1'b0, wb}));
		return s[30:15];
	endfunction

	// log2 in Q8.8: leading one position plus the next eight bits as fraction
	function automatic comp_t log2q(input logic [47:0] x);
		logic [5:0] p;
		logic [47:0] n;
		p = '0;
		for (int i = 0; i < 48; i++) begin
			if (x[i]) begin
				p = 6'(i);
			end
		end
		n = x << (6'd47 - p);
		return {2'b00, p, n[46:39]};
	endfunction

	// 2^e with e in Q8.8, result Q24.8; fraction approximated linearly
	function automatic logic [31:0] pow2q(input comp_t e);
		logic signed [7:0] ip;
		logic [8:0] mant;
		ip = e[15:8];
		mant = {1'b1, e[7:0]};
		if (ip[7]) begin
			return 32'(mant) >> 8'(-ip);
		end
		return 32'(mant) << ip[4:0];
	endfunction

	function automatic comp_t offset_for(input bw_t bw, input logic [9:0] rate);
		if (bw == BW_NB) begin
			return '0;
		end
		if (bw != BW_WB) begin
			return OFF_SUPER;
		end
		if (rate <= RATE_7K2) begin
			return OFF_R7K2;
		end
		if (rate <= RATE_8K0) begin
			return OFF_R8K0;
		end
		if (rate <= RATE_9K6) begin
			return OFF_R9K6;
		end
		return OFF_HIGH;
	endfunction

	// spectral distance between hangover mean and quantized vector
	always_comb begin
		dSum = '0;
		dk = '0;
		dMax = 17'(hangoverWeightedSpectralMean[0]) - 17'(quantVec[0]);
		for (int k = 0; k < VEC_LEN; k++) begin
			dk = 17'(hangoverWeightedSpectralMean[k]) - 17'(quantVec[k]);
			dSum = dSum + 21'(dk[16] ? -dk : dk);
			if (dk > dMax) begin
				dMax = dk;
			end
		end
		far = (dSum > 21'(DIST_SUM_THR)) || (dMax > 17'(DIST_MAX_THR));
	end

	// step flag and update hold, from this frame's inputs and the stored frame state
	always_comb begin
		firstInact = frameIn.inactive && !st.wasInactive;
		stepDiff = 17'(energyIn.instE) - 17'(energyIn.ltE);
		stepNow = frameIn.inactive && (stepDiff > 17'(STEP_THR));
		if (firstInact && frameIn.pastParams &&
			({2'b00, energyIn.enrNewest} > {energyIn.smoothedExcitationEnergy, 2'b00})) begin
			stepNow = 1'b1;
		end
		// descriptor energy compared as 2x against 3x to avoid a fractional factor
		holdUpd = st.afterFirstSid && !frameIn.sid &&
			({1'b0, st.lastSidE, 1'b0} >= ({1'b0, energyIn.smoothedExcitationEnergy, 1'b0} +
			{2'b00, energyIn.smoothedExcitationEnergy})) &&
			(frameIn.hoCount >= HANGOVER_MIN);
		offUpd = frameIn.firstSid && (frameIn.ioMode || frameIn.bw == BW_WB) &&
			(st.activeRun >= MIN_ACTIVE_FRAMES_FOR_OFFSET || !st.anySid);
	end

	// energy path: frame log energy, weighted history mean, quantizer, limiter
	always_comb begin
		eCur = log2q(st.sumSq) - (frameIn.core16k ? LOG2_L320 : LOG2_L256);
		newHist = {st.hist[HIST_LEN-2:0], eCur};
		acc = '0;
		for (int i = 0; i < HIST_LEN; i++) begin
			acc = acc + 40'(newHist[i] * $signed({1'b0, W_HIST[i]}));
		end
		wProd = acc * $signed({1'b0, W_NORM});
		newOff = offUpd ? offset_for(frameIn.bw, frameIn.rate) : st.offset;
		eAvg = wProd[WEIGHT_SHIFT+15:WEIGHT_SHIFT] - newOff;
		qProd = (24'(eAvg) + 24'(Q_BIAS)) * 24'(Q_STEP_NUM);
		qFloor = qProd >>> QUANT_SHIFT;
		if (qFloor < 0) begin
			rawIdx = '0;
		end else if (qFloor > $signed(24'(IDX_MAX))) begin
			rawIdx = IDX_MAX;
		end else begin
			rawIdx = qFloor[6:0];
		end
		iDiff = $signed({2'b00, rawIdx}) - $signed({2'b00, st.idx});
		sProd = 22'(iDiff * $signed({1'b0, STEP_FRAC}));
		stepSum = $signed({2'b00, st.idx}) + 9'(sProd >>> STEP_SHIFT);
		if (stepNow) begin
			idxNew = stepSum[6:0];
		end else if (st.wasInactive && ({1'b0, rawIdx} > ({1'b0, st.idx} + 8'h01))) begin
			idxNew = st.idx + 7'h01;
		end else begin
			idxNew = rawIdx;
		end
		eProd = idxNew * INV_STEP;
		eLogNew = comp_t'(eProd[22:QUANT_SHIFT]) - Q_BIAS;
	end

	// frame update; a residual sample coinciding with the strobe is dropped
	always_comb begin
		nx = st;
		nx.lpcStart = 1'b0;
		if (sampleValid) begin
			nx.sumSq = st.sumSq + 48'(residual * residual);
		end
		if (frameIn.strobe) begin
			nx.sumSq = '0;
			nx.lpcStart = 1'b1;
			if (!frameIn.inactive) begin
				nx.smVec = endVec;
				nx.wasInactive = 1'b0;
				nx.afterFirstSid = 1'b0;
				if (!(&st.activeRun)) begin
					nx.activeRun = st.activeRun + 8'h01;
				end
			end else begin
				if (frameIn.firstSid) begin
					if (stepNow || !frameIn.pastParams) begin
						nx.smVec = quantVec;
					end else if (far) begin
						nx.smVec = hangoverWeightedSpectralMean;
					end else begin
						for (int k = 0; k < VEC_LEN; k++) begin
							nx.smVec[k] = blend(hangoverWeightedSpectralMean[k],
								quantVec[k], INIT_HO, INIT_Q);
						end
					end
				end else if (!holdUpd) begin
					for (int k = 0; k < VEC_LEN; k++) begin
						nx.smVec[k] = blend(st.smVec[k], quantVec[k], SMOOTH_OLD,
							SMOOTH_NEW);
					end
				end
				if (frameIn.sid) begin
					nx.afterFirstSid = frameIn.firstSid;
					nx.anySid = 1'b1;
					nx.lastSidE = pow2q(eLogNew);
				end
				nx.hist = newHist;
				nx.offset = newOff;
				nx.idx = idxNew;
				nx.eLog = eLogNew;
				nx.eLin = pow2q(eLogNew);
				nx.stepFlag = stepNow;
				nx.wasInactive = 1'b1;
				nx.activeRun = '0;
			end
		end
	end

	// all frame state in one register, cleared by reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign result = '{st.smVec, st.idx, st.eLog, st.eLin, st.stepFlag};

	// coefficients follow the registered vector, eleven cycles after the strobe
	lsp_to_lpc coefConv (
		.clk   (clk),
		.rst_n (rst_n),
		.start (st.lpcStart),
		.lsp   (st.smVec),
		.coef  (lpcCoef),
		.valid (lpcValid)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_inact_frame;
		frameIn.strobe && frameIn.inactive;
	endsequence

	sequence s_first_sid;
		s_inact_frame ##0 frameIn.firstSid;
	endsequence

	sequence s_later_frame;
		s_inact_frame ##0 (!frameIn.firstSid && !holdUpd);
	endsequence

	a_smooth_toward_q: assert property (s_later_frame ##0 (quantVec[0] > st.smVec[0]) |=>
		st.smVec[0] >= $past(st.smVec[0]) && st.smVec[0] <= $past(quantVec[0]))
		else $error("smoothed component left the interval toward the new vector");
	a_hold_second_sid: assert property (s_inact_frame ##0 holdUpd |=> $stable(st.smVec))
		else $error("smoothed vector changed during an outlier hold");
	a_first_direct_load: assert property (s_first_sid ##0 (stepNow || !frameIn.pastParams)
		|=> st.smVec == $past(quantVec))
		else $error("first descriptor did not load the quantized vector");
	a_first_outlier: assert property (s_first_sid ##0 (!stepNow && frameIn.pastParams && far)
		|=> st.smVec == $past(hangoverWeightedSpectralMean))
		else $error("outlier descriptor did not load the hangover mean");
	a_active_end_load: assert property (frameIn.strobe && !frameIn.inactive
		|=> st.smVec == $past(endVec))
		else $error("active frame did not load the end-frame vector");
	a_offset_only_first: assert property (frameIn.strobe && !(frameIn.inactive &&
		frameIn.firstSid) |=> $stable(st.offset))
		else $error("energy offset changed outside a first descriptor");
	a_idx_rise_limit: assert property (s_inact_frame ##0 (st.wasInactive && !stepNow)
		|=> {1'b0, st.idx} <= {1'b0, $past(st.idx)} + 8'h01)
		else $error("index rose by more than one");
	a_step_direction: assert property (s_inact_frame ##0 stepNow
		|=> (st.idx >= $past(st.idx)) == ($past(rawIdx) >= $past(st.idx)))
		else $error("step index moved away from the raw index");
	a_coef_ready: assert property (st.lpcStart && !frameIn.strobe ##1 !frameIn.strobe[*8]
		##1 !frameIn.strobe |=> lpcValid)
		else $error("coefficients not ready eleven cycles after update");
	a_frame_hold: assert property (!frameIn.strobe |=> $stable(st.smVec) &&
		$stable(st.idx) && $stable(st.offset) && $stable(st.stepFlag))
		else $error("frame state changed without a strobe");
endmodule
`default_nettype wire

/* rtl/cn_smoother_pkg.sv */
`default_nettype none
package cn_smoother_pkg;
	localparam int VEC_LEN = 16;
	localparam int HIST_LEN = 8;
	localparam int POLY_LEN = 9;
	localparam int PROD_SHIFT = 12;
	localparam int COEF_SHIFT = 10;
	localparam int QUANT_SHIFT = 10;
	localparam int WEIGHT_SHIFT = 32;
	localparam int STEP_SHIFT = 12;

	// spectral components are Q2.13, log energies Q8.8
	typedef logic signed [15:0] comp_t;
	typedef comp_t [VEC_LEN-1:0] vec_t;
	typedef comp_t [VEC_LEN-1:0] lpc_t;
	typedef enum logic [1:0] {BW_NB, BW_WB, BW_SWB, BW_FB} bw_t;

	// per-frame control from the activity and hangover analysis
	typedef struct packed {
		logic       strobe;
		logic       inactive;
		logic       sid;
		logic       firstSid;
		logic       pastParams;
		logic       ioMode;
		bw_t        bw;
		logic       core16k;
		logic [9:0] rate;
		logic [3:0] hoCount;
	} frame_in_t;

	typedef struct packed {
		comp_t       instE;
		comp_t       ltE;
		logic [31:0] enrNewest;
		logic [31:0] smoothedExcitationEnergy;
	} energy_in_t;

	typedef struct packed {
		vec_t        smVec;
		logic [6:0]  idx;
		comp_t       eLog;
		logic [31:0] eLin;
		logic        stepFlag;
	} result_t;

	// smoothing weights, unsigned Q15
	localparam logic [15:0] SMOOTH_OLD = 16'h7333;
	localparam logic [15:0] SMOOTH_NEW = 16'h0CCD;
	localparam logic [15:0] INIT_HO = 16'h6666;
	localparam logic [15:0] INIT_Q = 16'h199A;
	// distance thresholds 0.4 and 0.1 in Q2.13
	localparam comp_t DIST_SUM_THR = 16'h0CCD;
	localparam comp_t DIST_MAX_THR = 16'h0333;
	localparam comp_t STEP_THR = 16'h0100;
	localparam logic [3:0] HANGOVER_MIN = 4'h3;
	localparam logic [7:0] MIN_ACTIVE_FRAMES_FOR_OFFSET = 8'h14;
	// log2 of 256 and 320 samples
	localparam comp_t LOG2_L256 = 16'h0800;
	localparam comp_t LOG2_L320 = 16'h0852;
	// history weights Q16, current frame at index 0
	localparam logic [HIST_LEN-1:0][15:0] W_HIST = {16'h02AF, 16'h0D6C, 16'h10C7,
		16'h14F9, 16'h1A37, 16'h20C5, 16'h28F6, 16'h3333};
	localparam logic [17:0] W_NORM = 18'h1_3FB0;
	// energy offsets Q8.8, rates in 100 bit/s
	localparam comp_t OFF_SUPER = 16'h0180;
	localparam comp_t OFF_R7K2 = 16'h01CB;
	localparam comp_t OFF_R8K0 = 16'h0165;
	localparam comp_t OFF_R9K6 = 16'h0119;
	localparam comp_t OFF_HIGH = 16'h00FF;
	localparam logic [9:0] RATE_7K2 = 10'h048;
	localparam logic [9:0] RATE_8K0 = 10'h050;
	localparam logic [9:0] RATE_9K6 = 10'h060;
	// quantizer: bias 2.0, step 5.25 as 21/4, 1/5.25 in Q10 x 256
	localparam comp_t Q_BIAS = 16'h0200;
	localparam comp_t Q_STEP_NUM = 16'h0015;
	localparam logic [15:0] INV_STEP = 16'hC30C;
	localparam logic [6:0] IDX_MAX = 7'h7F;
	localparam logic [11:0] STEP_FRAC = 12'hD9A;
	localparam logic signed [31:0] POLY_ONE = 32'h0010_0000;
	localparam logic [3:0] LPC_STEPS = 4'h8;
endpackage
`default_nettype wire

/* rtl/lsp_to_lpc.sv */
`default_nettype none
module lsp_to_lpc
	import cn_smoother_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	input  wire vec_t lsp,
	output var  lpc_t coef,
	output logic      valid
);
	typedef logic signed [31:0] wide_t;
	typedef wide_t [POLY_LEN-1:0] poly_t;
	typedef enum logic [1:0] {PH_IDLE, PH_EXPAND, PH_FINISH} phase_t;
	typedef struct packed {
		phase_t     phase;
		logic [3:0] step;
		poly_t      f1;
		poly_t      f2;
		lpc_t       coef;
		logic       valid;
	} lpc_state_t;

	lpc_state_t st;
	lpc_state_t nx;

	// multiply the polynomial by (1 - 2q z^-1 + z^-2), using old coefficients only
	function automatic poly_t factor(input poly_t f, input comp_t q);
		logic signed [47:0] m;
		wide_t prev2;
		factor = f;
		for (int j = 1; j < POLY_LEN; j++) begin
			prev2 = '0;
			if (j >= 2) begin
				prev2 = f[j-2];
			end
			m = 48'(q * f[j-1]);
			factor[j] = f[j] - 32'(m >>> PROD_SHIFT) + prev2;
		end
	endfunction

	// one factor per cycle keeps the multiplier count to one row per polynomial
	always_comb begin
		logic signed [32:0] s1;
		logic signed [32:0] s2;
		nx = st;
		nx.valid = 1'b0;
		s1 = '0;
		s2 = '0;
		case (st.phase)
			PH_IDLE: begin
			end
			PH_EXPAND: begin
				nx.f1 = factor(st.f1, lsp[2*st.step]);
				nx.f2 = factor(st.f2, lsp[2*st.step+1]);
				nx.step = st.step + 4'h1;
				if (st.step == LPC_STEPS - 4'h1) begin
					nx.phase = PH_FINISH;
				end
			end
			PH_FINISH: begin
				for (int i = 1; i < POLY_LEN; i++) begin
					s1 = 33'(st.f1[i]) + 33'(st.f1[i-1]);
					s2 = 33'(st.f2[i]) - 33'(st.f2[i-1]);
					nx.coef[i-1] = 16'((s1 + s2) >>> COEF_SHIFT);
					nx.coef[VEC_LEN-i] = 16'((s1 - s2) >>> COEF_SHIFT);
				end
				nx.valid = 1'b1;
				nx.phase = PH_IDLE;
			end
			default: nx.phase = PH_IDLE;
		endcase
		// a new start restarts the expansion from scratch
		if (start) begin
			nx.phase = PH_EXPAND;
			nx.step = '0;
			nx.f1 = '0;
			nx.f2 = '0;
			nx.f1[0] = POLY_ONE;
			nx.f2[0] = POLY_ONE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign coef = st.coef;
	assign valid = st.valid;
endmodule
`default_nettype wire
